//--- rtl/motor_ctrl_pkg.sv
// Constants for the motor user control register bank.
// Assumes a 32-bit memory-mapped port with word-aligned addresses.
package motor_ctrl_pkg;

	// Bank placement
	localparam logic [31:0] BANK_BASE = 32'h2020_0400;
	localparam logic [31:0] OFF_SPEED_CMD = 32'h0000_0000;
	localparam logic [31:0] OFF_DEBUG_CTRL = 32'h0000_0004;

	// Speed/torque command word layout
	localparam int SPEED_LSB = 0;
	localparam int SPEED_W = 15;
	localparam logic [31:0] SPEED_WMASK = 32'h0000_7FFF;
	localparam logic [31:0] SPEED_RESET = 32'h0000_0000;
	localparam int SPEED_FULL_SCALE = 32768;

	// Startup debug control word layout
	localparam int DBG_FAULT_CLR_BIT = 31;
	localparam int DBG_ANGLE_MSB = 30;
	localparam int DBG_ANGLE_LSB = 22;
	localparam int DBG_LOOP_OFF_BIT = 15;
	localparam int DBG_HOLD_ALIGN_BIT = 14;
	localparam int DBG_HOLD_SLOW_BIT = 13;
	localparam int DBG_HOLD_PROBE_BIT = 12;
	localparam int DBG_HOLD_SPIN_BIT = 11;
	localparam int DBG_ANGLE_SRC_BIT = 10;
	localparam logic [31:0] DEBUG_WMASK = 32'h7FC0_FC00;
	localparam logic [31:0] DEBUG_RESET = 32'h0000_0000;

	// Angle handling
	localparam int ANGLE_W = 9;
	localparam logic [8:0] ANGLE_WRAP = 9'h168;

	// Answer to an unmapped read
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// Startup method chosen by the input configuration
	typedef enum logic [1:0] {
		METHOD_ALIGN,
		METHOD_DOUBLE_ALIGN,
		METHOD_SLOW_FIRST_CYCLE,
		METHOD_POSITION_PROBE
	} startup_method_type;

endpackage : motor_ctrl_pkg

//--- rtl/angle_path_if.sv
// Carrier between the register bank and its angle reducer.
// Assumes both ends sit on the same clock; the path is combinational.
`timescale 1ns/1ns
interface angle_path_if;
	logic [8:0] forced_angle;
	logic [8:0] config_angle;
	logic use_forced;
	logic [8:0] held_angle;

	modport requester (
		output forced_angle,
		output config_angle,
		output use_forced,
		input held_angle
	);

	modport reducer (
		input forced_angle,
		input config_angle,
		input use_forced,
		output held_angle
	);
endinterface : angle_path_if

//--- rtl/angle_mod360.sv
// Chooses the alignment angle source and folds it into 0..359 degrees.
// Assumes inputs are 9-bit degree values; purely combinational.
`timescale 1ns/1ns
module angle_mod360 (
	// Angle path
	angle_path_if.reducer path
);

	wire [8:0] chosen_angle;
	wire over_range;

	assign chosen_angle = path.use_forced ? path.forced_angle
		: path.config_angle;

	// modulo 360
	// A 9-bit value never reaches 720, so one subtraction is enough
	assign over_range = (chosen_angle >= motor_ctrl_pkg::ANGLE_WRAP);
	assign path.held_angle = over_range
		? 9'(chosen_angle - motor_ctrl_pkg::ANGLE_WRAP) : chosen_angle;

endmodule : angle_mod360

//--- rtl/motor_user_control_regs.sv
// User control register bank of a sensorless field-oriented motor
// controller: speed/torque target and startup debug control word.
// Assumes a simple synchronous memory-mapped port on ref_clk, driven by
// logic in the same clock domain, and a startup state machine and fault
// logic outside that take the registered hold, clear and select outputs.
//
// Behaviour
// - Bank at base, speed 0, debug 4.
// - Speed target is 15 bits, low end.
// - Bit 31 clears faults, self-clears.
// - Forced angle bits 30:22, taken modulo 360.
// - Bit 15 turns feedback loop off.
// - Bit 14 holds alignment for align methods.
// - Bit 13 holds slow first cycle state.
// - Bit 12 holds position probe state.
// - Bit 11 holds spin detect if enabled.
// - Bit 10 selects forced or configured angle.
// - Both words reset zero; reserved read-only.
`timescale 1ns/1ns
module motor_user_control_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,

	// Register port
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata,
	output logic bus_ack,
	output logic bus_err,

	// Startup configuration from the input registers
	input wire motor_ctrl_pkg::startup_method_type startup_method,
	input wire logic spin_detect_enable,
	input wire logic [8:0] config_align_angle,

	// Controller commands
	output logic [14:0] speed_target,
	output logic fault_clear,
	output logic feedback_loop_off,
	output logic hold_align_state,
	output logic hold_slow_cycle_state,
	output logic hold_position_probe_state,
	output logic hold_spin_detect_state,
	output logic alignment_angle_source,
	output logic [8:0] align_angle_deg
);

	////////////////////////////////////////////////////////////////////
	// Address decode

	logic [31:0] speed_q;
	logic [31:0] speed_d;
	logic [31:0] debug_q;
	logic [31:0] debug_d;

	wire [31:0] bank_offset;
	wire hit_speed;
	wire hit_debug;
	wire hit_any;
	wire access;

	assign bank_offset = bus_addr - motor_ctrl_pkg::BANK_BASE;
	assign hit_speed = (bank_offset == motor_ctrl_pkg::OFF_SPEED_CMD);
	assign hit_debug = (bank_offset == motor_ctrl_pkg::OFF_DEBUG_CTRL);
	assign hit_any = hit_speed | hit_debug;
	assign access = bus_wr | bus_rd;

	wire wr_speed;
	wire wr_debug;

	assign wr_speed = bus_wr & hit_speed;
	assign wr_debug = bus_wr & hit_debug;

	////////////////////////////////////////////////////////////////////
	// Next register values

	assign speed_d = wr_speed
		? (bus_wdata & motor_ctrl_pkg::SPEED_WMASK) : speed_q;

	// reserved bits masked on write
	// Clear-fault bit is never stored, so it always reads back zero
	assign debug_d = wr_debug
		? (bus_wdata & motor_ctrl_pkg::DEBUG_WMASK) : debug_q;

	wire fault_clear_d;

	assign fault_clear_d = wr_debug
		& bus_wdata[motor_ctrl_pkg::DBG_FAULT_CLR_BIT];

	////////////////////////////////////////////////////////////////////
	// Field extraction

	wire [8:0] forced_angle;
	wire loop_off_bit;
	wire hold_align_bit;
	wire hold_slow_bit;
	wire hold_probe_bit;
	wire hold_spin_bit;
	wire angle_src_bit;

	assign forced_angle = debug_q[motor_ctrl_pkg::DBG_ANGLE_MSB:
		motor_ctrl_pkg::DBG_ANGLE_LSB];
	assign loop_off_bit = debug_q[motor_ctrl_pkg::DBG_LOOP_OFF_BIT];
	assign hold_align_bit = debug_q[motor_ctrl_pkg::DBG_HOLD_ALIGN_BIT];
	assign hold_slow_bit = debug_q[motor_ctrl_pkg::DBG_HOLD_SLOW_BIT];
	assign hold_probe_bit = debug_q[motor_ctrl_pkg::DBG_HOLD_PROBE_BIT];
	assign hold_spin_bit = debug_q[motor_ctrl_pkg::DBG_HOLD_SPIN_BIT];
	assign angle_src_bit = debug_q[motor_ctrl_pkg::DBG_ANGLE_SRC_BIT];

	////////////////////////////////////////////////////////////////////
	// Startup hold qualification

	wire method_align;
	wire method_slow;
	wire method_probe;

	assign method_align =
		(startup_method == motor_ctrl_pkg::METHOD_ALIGN) ||
		(startup_method == motor_ctrl_pkg::METHOD_DOUBLE_ALIGN);
	assign method_slow =
		(startup_method == motor_ctrl_pkg::METHOD_SLOW_FIRST_CYCLE);
	assign method_probe =
		(startup_method == motor_ctrl_pkg::METHOD_POSITION_PROBE);

	wire hold_align_d;
	wire hold_slow_d;
	wire hold_probe_d;
	wire hold_spin_d;

	// align hold only for align methods
	assign hold_align_d = hold_align_bit & method_align;
	assign hold_slow_d = hold_slow_bit & method_slow;
	assign hold_probe_d = hold_probe_bit & method_probe;
	assign hold_spin_d = hold_spin_bit & spin_detect_enable;

	////////////////////////////////////////////////////////////////////
	// Alignment angle path

	angle_path_if angle_path ();

	assign angle_path.forced_angle = forced_angle;
	assign angle_path.config_angle = config_align_angle;
	assign angle_path.use_forced = angle_src_bit;

	angle_mod360 u_angle (
		.path(angle_path.reducer)
	);

	////////////////////////////////////////////////////////////////////
	// Read data

	wire [31:0] read_word;

	// reserved bits read zero
	// Read returns the value held before a same-cycle write
	assign read_word = hit_speed ? speed_q
		: hit_debug ? debug_q
		: motor_ctrl_pkg::UNMAPPED_DATA;

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			speed_q <= motor_ctrl_pkg::SPEED_RESET;
			debug_q <= motor_ctrl_pkg::DEBUG_RESET;
		end else begin
			speed_q <= speed_d;
			debug_q <= debug_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			fault_clear <= 1'b0;
		end else begin
			fault_clear <= fault_clear_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			feedback_loop_off <= 1'b0;
			alignment_angle_source <= 1'b0;
		end else begin
			feedback_loop_off <= loop_off_bit;
			alignment_angle_source <= angle_src_bit;
		end
	end

	// Hold outputs lag the stored bits by one cycle
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			hold_align_state <= 1'b0;
			hold_slow_cycle_state <= 1'b0;
			hold_position_probe_state <= 1'b0;
			hold_spin_detect_state <= 1'b0;
		end else begin
			hold_align_state <= hold_align_d;
			hold_slow_cycle_state <= hold_slow_d;
			hold_position_probe_state <= hold_probe_d;
			hold_spin_detect_state <= hold_spin_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			speed_target <= '0;
			align_angle_deg <= '0;
		end else begin
			speed_target <= speed_q[motor_ctrl_pkg::SPEED_W-1:
				motor_ctrl_pkg::SPEED_LSB];
			align_angle_deg <= angle_path.held_angle;
		end
	end

	// Every access is answered one cycle later; unmapped ones flag error
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bus_rdata <= '0;
			bus_ack <= 1'b0;
			bus_err <= 1'b0;
		end else begin
			bus_rdata <= bus_rd ? read_word : '0;
			bus_ack <= access;
			bus_err <= access & ~hit_any;
		end
	end

endmodule : motor_user_control_regs

//--- verif/motor_regs_checker_sva.sv
// Assertions on the motor user control bank's ports.
// Assumes binding to the bank's top module; one clock domain.
`timescale 1ns/1ns
module motor_regs_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_ack,
	input wire logic bus_err,
	// Configuration and commands
	input wire motor_ctrl_pkg::startup_method_type startup_method,
	input wire logic spin_detect_enable,
	input wire logic [8:0] config_align_angle,
	input wire logic [14:0] speed_target,
	input wire logic fault_clear,
	input wire logic feedback_loop_off,
	input wire logic hold_align_state,
	input wire logic hold_slow_cycle_state,
	input wire logic hold_position_probe_state,
	input wire logic hold_spin_detect_state,
	input wire logic alignment_angle_source,
	input wire logic [8:0] align_angle_deg
);
	wire logic req = bus_wr | bus_rd;
	wire logic hit_spd = bus_addr == motor_ctrl_pkg::BANK_BASE;
	wire logic hit_dbg = bus_addr == (motor_ctrl_pkg::BANK_BASE + 32'h4);
	wire logic clr_req = bus_wr & hit_dbg & bus_wdata[31];
	wire logic [8:0] cfg_fold = (config_align_angle >= 9'h168) ?
		config_align_angle - 9'h168 : config_align_angle;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////
	AST_ACK:
	assert property (req |=> bus_ack) else $error("no ack");
	AST_UNMAPPED:
	assert property (req && !hit_spd && !hit_dbg |=> bus_err)
		else $error("no error on unmapped");
	AST_SPEED:
	assert property (bus_wr && hit_spd |=> ##1
		speed_target == $past(bus_wdata[14:0], 2))
		else $error("speed target wrong");
	AST_FAULT:
	assert property (fault_clear |-> $past(clr_req))
		else $error("stray fault clear");
	AST_FAULT_FWD:
	assert property (clr_req |=> fault_clear) else $error("no fault clear");
	AST_DBG_MASK:
	assert property (bus_rd && hit_dbg |=>
		(bus_rdata & ~motor_ctrl_pkg::DEBUG_WMASK) == 32'h0)
		else $error("reserved bits read");
	AST_HOLD_ALIGN:
	assert property (hold_align_state |-> $past(startup_method) inside
		{motor_ctrl_pkg::METHOD_ALIGN, motor_ctrl_pkg::METHOD_DOUBLE_ALIGN})
		else $error("align hold wrong");
	AST_HOLD_SLOW:
	assert property (hold_slow_cycle_state |->
		$past(startup_method) == motor_ctrl_pkg::METHOD_SLOW_FIRST_CYCLE)
		else $error("slow hold wrong");
	AST_HOLD_PROBE:
	assert property (hold_position_probe_state |->
		$past(startup_method) == motor_ctrl_pkg::METHOD_POSITION_PROBE)
		else $error("probe hold wrong");
	AST_HOLD_SPIN:
	assert property (hold_spin_detect_state |-> $past(spin_detect_enable))
		else $error("spin hold wrong");
	AST_ANGLE_CFG:
	assert property ($past(nrst) && $past(nrst, 2) && !alignment_angle_source
		|-> align_angle_deg == $past(cfg_fold))
		else $error("config angle wrong");
	AST_ANGLE_RANGE:
	assert property (align_angle_deg < 9'h168) else $error("angle over 359");
	AST_LOOP_OFF:
	assert property (bus_wr && hit_dbg |=> ##1
		feedback_loop_off == $past(bus_wdata[15], 2))
		else $error("loop off wrong");
	cover property (clr_req);
	cover property (feedback_loop_off);
	cover property (hold_align_state);
	cover property (bus_err);
endmodule : motor_regs_checker

//--- verif/motor_user_control_regs_test.sv
// Self-checking bench for the motor user control register bank.
// Assumes the package and design are compiled first.
`timescale 1ns/1ns
module motor_user_control_regs_test;
	localparam logic [31:0] SPD = motor_ctrl_pkg::BANK_BASE;
	localparam logic [31:0] DBG = SPD + 32'h4;
	typedef struct {logic [31:0] a, d, rb; logic er;} row_type;
	row_type rows [6] = '{'{SPD, 32'hFFFF_FFFF, 32'h0000_7FFF, 1'b0},
		'{SPD, 32'h0000_1234, 32'h0000_1234, 1'b0},
		'{DBG, 32'hFFFF_FFFF, 32'h7FC0_FC00, 1'b0},
		'{DBG, 32'h8000_8000, 32'h0000_8000, 1'b0},
		'{SPD + 32'h8, 32'h0000_0001, 32'h0000_0000, 1'b1},
		'{DBG, 32'h0000_0000, 32'h0000_0000, 1'b0}};
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] bus_addr = 32'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [31:0] bus_wdata = 32'h0;
	logic [31:0] bus_rdata, q;
	logic bus_ack, bus_err, e;
	motor_ctrl_pkg::startup_method_type startup_method;
	logic spin_detect_enable = 1'b1;
	logic [8:0] config_align_angle = 9'h0;
	logic [14:0] speed_target;
	logic [8:0] align_angle_deg;
	logic fault_clear, feedback_loop_off, hold_align_state;
	logic hold_slow_cycle_state, hold_position_probe_state;
	logic hold_spin_detect_state, alignment_angle_source;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	motor_user_control_regs i_motor_user_control_regs (.ref_clk, .nrst,
		.bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_ack,
		.bus_err, .startup_method, .spin_detect_enable, .config_align_angle,
		.speed_target, .fault_clear, .feedback_loop_off, .hold_align_state,
		.hold_slow_cycle_state, .hold_position_probe_state,
		.hold_spin_detect_state, .alignment_angle_source, .align_angle_deg);

	always #4 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp, string what);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task end_of_test;
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// One access; the answer stands only in the cycle after the take edge
	task acc(input logic w, r, input logic [31:0] a, d);
		@(negedge ref_clk);
		bus_wr = w;
		bus_rd = r;
		bus_addr = a;
		bus_wdata = d;
		@(negedge ref_clk);
		chk(bus_ack, 1, "bus_ack");
		q = bus_rdata;
		e = bus_err;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	endtask : acc

	// Hang guard: the sequence needs about 60 cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			n_errors++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		startup_method = motor_ctrl_pkg::METHOD_ALIGN;
		repeat (5) @(negedge ref_clk);
		nrst = 1'b1;
		acc(0, 1, DBG, 0);
		chk(q, 0, "debug reset");
		foreach (rows[i]) begin
			acc(1, 0, rows[i].a, rows[i].d);
			chk(e, rows[i].er, "bus_err");
			acc(0, 1, rows[i].a, 0);
			chk(q, rows[i].rb, "readback");
			@(negedge ref_clk);
			if (rows[i].a == SPD)
				chk(speed_target, rows[i].rb[14:0], "speed");
			if (rows[i].a == DBG)
				chk(feedback_loop_off, rows[i].rb[15], "loop off");
		end
		acc(1, 0, DBG, 32'h8000_0000);
		chk(fault_clear, 1, "fault_clear");
		@(negedge ref_clk);
		chk(fault_clear, 0, "fault_clear end");
		acc(1, 0, DBG, 32'h0000_7800);
		for (int m = 0; m < 4; m++) begin
			startup_method = motor_ctrl_pkg::startup_method_type'(m);
			@(negedge ref_clk);
			chk(hold_align_state, m < 2, "hold align");
			chk(hold_slow_cycle_state, m == 2, "hold slow");
			chk(hold_position_probe_state, m == 3, "hold probe");
			chk(hold_spin_detect_state, 1, "hold spin");
		end
		spin_detect_enable = 1'b0;
		@(negedge ref_clk);
		chk(hold_spin_detect_state, 0, "spin off");
		acc(1, 0, DBG, 32'h6400_0400);
		@(negedge ref_clk);
		chk(alignment_angle_source, 1, "angle src");
		chk(align_angle_deg, 9'h028, "forced angle");
		acc(1, 0, DBG, 0);
		config_align_angle = 9'h1FF;
		@(negedge ref_clk);
		chk(align_angle_deg, 9'h097, "config angle");
		nrst = 1'b0;
		@(negedge ref_clk);
		nrst = 1'b1;
		chk(speed_target, 0, "speed reset");
		acc(0, 1, SPD, 0);
		chk(q, 0, "speed word reset");
		end_of_test();
	end
endmodule : motor_user_control_regs_test

bind motor_user_control_regs motor_regs_checker i_motor_regs_checker (
	.ref_clk, .nrst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
	.bus_ack, .bus_err, .startup_method, .spin_detect_enable,
	.config_align_angle, .speed_target, .fault_clear, .feedback_loop_off,
	.hold_align_state, .hold_slow_cycle_state, .hold_position_probe_state,
	.hold_spin_detect_state, .alignment_angle_source, .align_angle_deg);
